// ===== rtl/sfcf_engine.v
// Scatter-fill and cache-flush descriptor execution engine
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "sfcf_regs.vh"

module sfcf_engine #(
	parameter LINE_LOG2 = 6,
	parameter [31:0] CAP_WORD0 = 32'h0000_0001
) (
	// Clock and reset
	input wire I_CLK,
	input wire I_RST,
	// Register port
	input wire [5:0] I_ADDR,
	input wire [31:0] I_WDATA,
	input wire I_WR,
	input wire I_RD,
	output reg [31:0] O_RDATA,
	// Engine state
	output reg O_BUSY,
	output reg O_DONE,
	// Memory request port, held until acknowledged
	output reg O_MEM_REQ,
	output reg [1:0] O_MEM_CMD,
	output reg [63:0] O_MEM_ADDR,
	output reg [63:0] O_MEM_WDATA,
	output reg [7:0] O_MEM_BE,
	output reg O_MEM_HID_EN,
	output reg [15:0] O_MEM_HID,
	input wire I_MEM_ACK,
	input wire I_MEM_FAULT,
	input wire [63:0] I_MEM_RDATA
);

	localparam [5:0] S_IDLE = 6'b000001;
	localparam [5:0] S_LIST = 6'b000010;
	localparam [5:0] S_FILL = 6'b000100;
	localparam [5:0] S_FLUSH = 6'b001000;
	localparam [5:0] S_REC = 6'b010000;
	localparam [5:0] S_END = 6'b100000;
	localparam [63:0] LINE_MASK = ~((64'h0000_0000_0000_0001 << LINE_LOG2) - 64'h0000_0000_0000_0001);

	// Byte lanes for n bytes starting at lane lo
	function [7:0] be_mask;
		input [2:0] lo;
		input [3:0] n;
		reg [7:0] t;
		begin
			t = 8'hFF >> (4'h8 - n);
			be_mask = t << lo;
		end
	endfunction

	// Pattern byte k of a block lands on lane (start + k) mod 8
	function [63:0] rot_pat;
		input [63:0] p;
		input [2:0] s;
		begin
			rot_pat = (p << {s, 3'b000}) | (p >> (7'h40 - {1'b0, s, 3'b000}));
		end
	endfunction

	reg [5:0] state_ff;
	reg [7:0] op_ff;
	reg [23:0] flags_ff;
	reg [63:0] crec_ff;
	reg [63:0] pat_ff;
	reg [63:0] dest_ff;
	reg [31:0] xfer_ff;
	reg [31:0] ecount_ff;
	reg [31:0] sglsize_ff;
	reg [7:0] dtype_ff;
	reg [15:0] hid_ff;
	reg [31:0] bdone_ff;
	reg [31:0] edone_ff;
	reg [7:0] status_ff;
	reg [7:0] finfo_ff;
	reg [63:0] faddr_ff;
	reg [63:0] cur_ff;
	reg [63:0] last_ff;
	reg [39:0] rem_ff;
	reg [1:0] beat_ff;
	reg done_ff;

	wire start = I_WR && (I_ADDR == `SFCF_A_CTRL) && I_WDATA[0] && !O_BUSY;
	wire cfg_wr = I_WR && !O_BUSY;
	wire [39:0] blk_size = {8'h00, ecount_ff} << dtype_ff[1:0];
	wire alt_dst = flags_ff[`SFCF_FLAG_ALT_DST] && CAP_WORD0[`SFCF_CAP_SFILL_BIT];
	wire [3:0] gap = 4'h8 - {1'b0, cur_ff[2:0]};
	wire [3:0] beat_n = (rem_ff < {36'h0_0000_0000, gap}) ? rem_ff[3:0] : gap;
	wire [63:0] flush_end = dest_ff + {32'h0000_0000, xfer_ff} - 64'h0000_0000_0000_0001;
	wire [63:0] list_addr = dest_ff + ({32'h0000_0000, edone_ff} << 3);
	wire is_sfill = (op_ff == `SFCF_OP_SFILL);
	wire ack = O_MEM_REQ && I_MEM_ACK;

	// Register reads: data stands only in the cycle after the strobe
	always @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			O_RDATA <= `SFCF_RST_WORD;
		end else if (I_RD) begin
			case (I_ADDR)
				`SFCF_A_STATUS: O_RDATA <= {16'h0000, status_ff, 6'h00, done_ff, O_BUSY};
				`SFCF_A_OPFLAGS: O_RDATA <= {op_ff, flags_ff};
				`SFCF_A_CREC_LO: O_RDATA <= crec_ff[31:0];
				`SFCF_A_CREC_HI: O_RDATA <= crec_ff[63:32];
				`SFCF_A_PAT_LO: O_RDATA <= pat_ff[31:0];
				`SFCF_A_PAT_HI: O_RDATA <= pat_ff[63:32];
				`SFCF_A_DEST_LO: O_RDATA <= dest_ff[31:0];
				`SFCF_A_DEST_HI: O_RDATA <= dest_ff[63:32];
				`SFCF_A_XFER: O_RDATA <= xfer_ff;
				`SFCF_A_ECOUNT: O_RDATA <= ecount_ff;
				`SFCF_A_SGLSIZE: O_RDATA <= sglsize_ff;
				`SFCF_A_DTYPE: O_RDATA <= {hid_ff, 8'h00, dtype_ff};
				`SFCF_A_CAP: O_RDATA <= CAP_WORD0;
				`SFCF_A_BDONE: O_RDATA <= bdone_ff;
				`SFCF_A_EDONE: O_RDATA <= edone_ff;
				default: O_RDATA <= `SFCF_RST_WORD;
			endcase
		end else begin
			O_RDATA <= `SFCF_RST_WORD;
		end
	end

	// Descriptor fields; frozen while a descriptor runs
	always @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			op_ff <= 8'h00;
			flags_ff <= 24'h00_0000;
			crec_ff <= `SFCF_RST_QWORD;
			pat_ff <= `SFCF_RST_QWORD;
			dest_ff <= `SFCF_RST_QWORD;
			xfer_ff <= `SFCF_RST_WORD;
			ecount_ff <= `SFCF_RST_WORD;
			sglsize_ff <= `SFCF_RST_WORD;
			dtype_ff <= 8'h00;
			hid_ff <= 16'h0000;
		end else if (cfg_wr) begin
			case (I_ADDR)
				`SFCF_A_OPFLAGS: begin
					op_ff <= I_WDATA[31:24];
					flags_ff <= I_WDATA[23:0];
				end
				`SFCF_A_CREC_LO: crec_ff[31:0] <= I_WDATA;
				`SFCF_A_CREC_HI: crec_ff[63:32] <= I_WDATA;
				`SFCF_A_PAT_LO: pat_ff[31:0] <= I_WDATA;
				`SFCF_A_PAT_HI: pat_ff[63:32] <= I_WDATA;
				`SFCF_A_DEST_LO: dest_ff[31:0] <= I_WDATA;
				`SFCF_A_DEST_HI: dest_ff[63:32] <= I_WDATA;
				`SFCF_A_XFER: xfer_ff <= I_WDATA;
				`SFCF_A_ECOUNT: ecount_ff <= I_WDATA;
				`SFCF_A_SGLSIZE: sglsize_ff <= I_WDATA;
				`SFCF_A_DTYPE: begin
					dtype_ff <= I_WDATA[7:0];
					hid_ff <= I_WDATA[31:16];
				end
				default: begin
				end
			endcase
		end
	end

	// Execution sequencer
	always @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			state_ff <= S_IDLE;
			O_BUSY <= 1'b0;
			O_DONE <= 1'b0;
			done_ff <= 1'b0;
			O_MEM_REQ <= 1'b0;
			O_MEM_CMD <= `SFCF_CMD_READ;
			O_MEM_ADDR <= `SFCF_RST_QWORD;
			O_MEM_WDATA <= `SFCF_RST_QWORD;
			O_MEM_BE <= 8'h00;
			O_MEM_HID_EN <= 1'b0;
			O_MEM_HID <= 16'h0000;
			bdone_ff <= `SFCF_RST_WORD;
			edone_ff <= `SFCF_RST_WORD;
			status_ff <= `SFCF_ST_NONE;
			finfo_ff <= 8'h00;
			faddr_ff <= `SFCF_RST_QWORD;
			cur_ff <= `SFCF_RST_QWORD;
			last_ff <= `SFCF_RST_QWORD;
			rem_ff <= 40'h00_0000_0000;
			beat_ff <= 2'h0;
		end else begin
			O_DONE <= 1'b0;
			if (ack) begin
				O_MEM_REQ <= 1'b0;
			end
			case (state_ff)
				S_IDLE: begin
					if (start) begin
						O_BUSY <= 1'b1;
						done_ff <= 1'b0;
						bdone_ff <= `SFCF_RST_WORD;
						edone_ff <= `SFCF_RST_WORD;
						finfo_ff <= 8'h00;
						faddr_ff <= `SFCF_RST_QWORD;
						status_ff <= `SFCF_ST_SUCCESS;
						beat_ff <= 2'h0;
						if (op_ff == `SFCF_OP_SFILL) begin
							state_ff <= (sglsize_ff == `SFCF_RST_WORD) ? S_REC : S_LIST;
						end else if (op_ff == `SFCF_OP_FLUSH) begin
							// Round both ends down to a line so partial lines are covered
							cur_ff <= dest_ff & LINE_MASK;
							last_ff <= flush_end & LINE_MASK;
							state_ff <= (xfer_ff == `SFCF_RST_WORD) ? S_REC : S_FLUSH;
						end else begin
							status_ff <= `SFCF_ST_BADOP;
							state_ff <= S_REC;
						end
					end
				end
				S_LIST: begin
					if (!O_MEM_REQ) begin
						O_MEM_REQ <= 1'b1;
						O_MEM_CMD <= `SFCF_CMD_READ;
						O_MEM_ADDR <= list_addr;
						O_MEM_BE <= 8'hFF;
						O_MEM_HID_EN <= 1'b0;
						// A handle left from the last fill beat must not leak
						O_MEM_HID <= 16'h0000;
					end else if (ack) begin
						if (I_MEM_FAULT) begin
							status_ff <= `SFCF_ST_PFAULT;
							finfo_ff <= `SFCF_FI_LIST;
							faddr_ff <= O_MEM_ADDR;
							state_ff <= S_REC;
						end else if (blk_size == 40'h00_0000_0000) begin
							edone_ff <= edone_ff + 32'h0000_0001;
							state_ff <= (edone_ff + 32'h0000_0001 == sglsize_ff) ? S_REC : S_LIST;
						end else begin
							cur_ff <= I_MEM_RDATA;
							rem_ff <= blk_size;
							state_ff <= S_FILL;
						end
					end
				end
				S_FILL: begin
					if (!O_MEM_REQ) begin
						O_MEM_REQ <= 1'b1;
						O_MEM_CMD <= `SFCF_CMD_WRITE;
						O_MEM_ADDR <= {cur_ff[63:3], 3'b000};
						O_MEM_BE <= be_mask(cur_ff[2:0], beat_n);
						// Pattern phase tracks the block start, not the lane
						O_MEM_WDATA <= rot_pat(pat_ff, cur_ff[2:0] - blk_size[2:0] + rem_ff[2:0]);
						O_MEM_HID_EN <= alt_dst;
						O_MEM_HID <= alt_dst ? hid_ff : 16'h0000;
					end else if (ack) begin
						if (I_MEM_FAULT) begin
							status_ff <= `SFCF_ST_PFAULT;
							finfo_ff <= `SFCF_FI_WRITE;
							faddr_ff <= cur_ff;
							state_ff <= S_REC;
						end else begin
							cur_ff <= cur_ff + {60'h000_0000_0000_0000, beat_n};
							rem_ff <= rem_ff - {36'h0_0000_0000, beat_n};
							bdone_ff <= bdone_ff + {28'h000_0000, beat_n};
							if (rem_ff == {36'h0_0000_0000, beat_n}) begin
								edone_ff <= edone_ff + 32'h0000_0001;
								state_ff <= (edone_ff + 32'h0000_0001 == sglsize_ff) ? S_REC : S_LIST;
							end
						end
					end
				end
				S_FLUSH: begin
					if (!O_MEM_REQ) begin
						O_MEM_REQ <= 1'b1;
						O_MEM_CMD <= `SFCF_CMD_FLUSH;
						O_MEM_ADDR <= cur_ff;
						O_MEM_BE <= 8'h00;
						O_MEM_HID_EN <= 1'b0;
						O_MEM_HID <= 16'h0000;
					end else if (ack) begin
						if (I_MEM_FAULT) begin
							status_ff <= `SFCF_ST_PFAULT;
							finfo_ff <= `SFCF_FI_WRITE;
							faddr_ff <= cur_ff;
							// Bytes below the faulting line already flushed
							bdone_ff <= (cur_ff > dest_ff) ? cur_ff[31:0] - dest_ff[31:0] : `SFCF_RST_WORD;
							state_ff <= S_REC;
						end else if (cur_ff == last_ff) begin
							state_ff <= S_REC;
						end else begin
							cur_ff <= cur_ff + (64'h0000_0000_0000_0001 << LINE_LOG2);
						end
					end
				end
				S_REC: begin
					// Record beats carry no handle; a fault on them is not reported
					if (!O_MEM_REQ) begin
						O_MEM_REQ <= 1'b1;
						O_MEM_CMD <= `SFCF_CMD_WRITE;
						O_MEM_ADDR <= crec_ff + {59'h000_0000_0000_0000, beat_ff, 3'b000};
						O_MEM_BE <= 8'hFF;
						O_MEM_HID_EN <= 1'b0;
						O_MEM_HID <= 16'h0000;
						case (beat_ff)
							2'h0: O_MEM_WDATA <= (status_ff == `SFCF_ST_PFAULT) ?
								{bdone_ff, 8'h00, finfo_ff, 8'h00, status_ff} :
								{48'h0000_0000_0000, 8'h00, status_ff};
							2'h1: O_MEM_WDATA <= faddr_ff;
							default: O_MEM_WDATA <= (is_sfill && status_ff == `SFCF_ST_PFAULT) ?
								{edone_ff, 16'h0000, alt_dst ? hid_ff : 16'h0000} :
								`SFCF_RST_QWORD;
						endcase
					end else if (ack) begin
						beat_ff <= beat_ff + 2'h1;
						if (beat_ff == `SFCF_REC_BEATS - 2'h1) begin
							state_ff <= S_END;
						end
					end
				end
				S_END: begin
					// Progress counters read back as zero once all went well
					if (status_ff == `SFCF_ST_SUCCESS) begin
						bdone_ff <= `SFCF_RST_WORD;
						edone_ff <= `SFCF_RST_WORD;
					end
					O_BUSY <= 1'b0;
					O_DONE <= 1'b1;
					done_ff <= 1'b1;
					state_ff <= S_IDLE;
				end
				default: begin
					state_ff <= S_IDLE;
				end
			endcase
		end
	end

endmodule

// ===== rtl/sfcf_regs.vh
// Register map, descriptor encodings and record layout for the fill/flush engine
`ifndef SFCF_REGS_VH
`define SFCF_REGS_VH

`define SFCF_A_CTRL 6'h00
`define SFCF_A_STATUS 6'h04
`define SFCF_A_OPFLAGS 6'h08
`define SFCF_A_CREC_LO 6'h0C
`define SFCF_A_CREC_HI 6'h10
`define SFCF_A_PAT_LO 6'h14
`define SFCF_A_PAT_HI 6'h18
`define SFCF_A_DEST_LO 6'h1C
`define SFCF_A_DEST_HI 6'h20
`define SFCF_A_XFER 6'h24
`define SFCF_A_ECOUNT 6'h28
`define SFCF_A_SGLSIZE 6'h2C
`define SFCF_A_DTYPE 6'h30
`define SFCF_A_CAP 6'h34
`define SFCF_A_BDONE 6'h38
`define SFCF_A_EDONE 6'h3C

`define SFCF_OP_SFILL 8'h1E
`define SFCF_OP_FLUSH 8'h20
`define SFCF_FLAG_ALT_DST 17
`define SFCF_CAP_SFILL_BIT 0

`define SFCF_ST_NONE 8'h00
`define SFCF_ST_SUCCESS 8'h01
`define SFCF_ST_PFAULT 8'h03
`define SFCF_ST_BADOP 8'h10
`define SFCF_FI_WRITE 8'h01
`define SFCF_FI_LIST 8'h02

`define SFCF_CMD_READ 2'h0
`define SFCF_CMD_WRITE 2'h1
`define SFCF_CMD_FLUSH 2'h2

`define SFCF_SGL_STRIDE 64'h0000_0000_0000_0008
`define SFCF_REC_BEATS 2'h3
`define SFCF_RST_WORD 32'h0000_0000
`define SFCF_RST_QWORD 64'h0000_0000_0000_0000

`endif

// ===== sim/sfcf_engine_props.sv
// Port-level assertions for the fill and flush engine
`timescale 1ns/1ps
`include "sfcf_regs.vh"
module sfcf_engine_props #(
	parameter LINE_LOG2 = 6
) (
	input wire I_CLK,
	input wire I_RST,
	input wire I_RD,
	input wire [31:0] O_RDATA,
	input wire O_BUSY,
	input wire O_DONE,
	input wire O_MEM_REQ,
	input wire [1:0] O_MEM_CMD,
	input wire [63:0] O_MEM_ADDR,
	input wire [7:0] O_MEM_BE,
	input wire O_MEM_HID_EN,
	input wire [15:0] O_MEM_HID,
	input wire I_MEM_ACK
);
	default clocking @(posedge I_CLK); endclocking
	default disable iff (I_RST);
	a_req_hold: assert property (O_MEM_REQ && !I_MEM_ACK |=> O_MEM_REQ &&
		$stable(O_MEM_ADDR) && $stable(O_MEM_CMD) && $stable(O_MEM_BE)) else $error("req moved");
	a_req_gap: assert property (O_MEM_REQ && I_MEM_ACK |=> !O_MEM_REQ)
		else $error("no idle after ack");
	a_rdata_idle: assert property (!$past(I_RD) |-> O_RDATA == 32'h0000_0000)
		else $error("read data outside slot");
	a_done_pulse: assert property (O_DONE |=> !O_DONE && !O_BUSY)
		else $error("done not a pulse");
	a_req_in_busy: assert property (O_MEM_REQ |-> O_BUSY)
		else $error("request while idle");
	a_busy_end: assert property ($fell(O_BUSY) |-> O_DONE || $past(O_DONE))
		else $error("busy fell without done");
	a_hid_gated: assert property (O_MEM_REQ && !O_MEM_HID_EN |-> O_MEM_HID == 16'h0000)
		else $error("handle without enable");
	a_flush_line: assert property (O_MEM_REQ && O_MEM_CMD == `SFCF_CMD_FLUSH |->
		(O_MEM_ADDR & ((64'h1 << LINE_LOG2) - 64'h1)) == '0 && O_MEM_BE == 8'h00)
		else $error("flush not line aligned");
	a_beat_align: assert property (O_MEM_REQ && O_MEM_CMD != `SFCF_CMD_FLUSH |->
		O_MEM_ADDR[2:0] == 3'h0) else $error("beat not aligned");
	a_write_lanes: assert property (O_MEM_REQ && O_MEM_CMD == `SFCF_CMD_WRITE |->
		O_MEM_BE != 8'h00) else $error("empty write");
endmodule
bind sfcf_engine sfcf_engine_props #(.LINE_LOG2(LINE_LOG2)) u_sfcf_engine_props (
	.I_CLK(I_CLK), .I_RST(I_RST), .I_RD(I_RD), .O_RDATA(O_RDATA), .O_BUSY(O_BUSY),
	.O_DONE(O_DONE), .O_MEM_REQ(O_MEM_REQ), .O_MEM_CMD(O_MEM_CMD), .O_MEM_ADDR(O_MEM_ADDR),
	.O_MEM_BE(O_MEM_BE), .O_MEM_HID_EN(O_MEM_HID_EN), .O_MEM_HID(O_MEM_HID),
	.I_MEM_ACK(I_MEM_ACK));

// ===== sim/sfcf_engine_tb.sv
// Self-checking bench for the fill and flush engine
`timescale 1ns/1ps
`include "sfcf_regs.vh"
module scatter_fill_and_cache_flush_tb;
	logic I_CLK = 0, I_RST = 1, I_WR = 0, I_RD = 0, O_BUSY, O_DONE, O_MEM_REQ, O_MEM_HID_EN;
	logic I_MEM_ACK, I_MEM_FAULT;
	logic [5:0] I_ADDR = 0;
	logic [31:0] I_WDATA = 0, O_RDATA;
	logic [1:0] O_MEM_CMD;
	logic [63:0] O_MEM_ADDR, O_MEM_WDATA, I_MEM_RDATA;
	logic [7:0] O_MEM_BE;
	logic [15:0] O_MEM_HID;
	int bad_count = 0, checked = 0;
	sfcf_engine u_sfcf_engine (.I_CLK(I_CLK), .I_RST(I_RST), .I_ADDR(I_ADDR),
		.I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .O_BUSY(O_BUSY),
		.O_DONE(O_DONE), .O_MEM_REQ(O_MEM_REQ), .O_MEM_CMD(O_MEM_CMD),
		.O_MEM_ADDR(O_MEM_ADDR), .O_MEM_WDATA(O_MEM_WDATA), .O_MEM_BE(O_MEM_BE),
		.O_MEM_HID_EN(O_MEM_HID_EN), .O_MEM_HID(O_MEM_HID), .I_MEM_ACK(I_MEM_ACK),
		.I_MEM_FAULT(I_MEM_FAULT), .I_MEM_RDATA(I_MEM_RDATA));
	sfcf_mem_model u_sfcf_mem_model (.i_clk(I_CLK), .i_rst(I_RST), .i_req(O_MEM_REQ),
		.i_cmd(O_MEM_CMD), .i_addr(O_MEM_ADDR), .i_wdata(O_MEM_WDATA), .i_be(O_MEM_BE),
		.i_hid_en(O_MEM_HID_EN), .i_hid(O_MEM_HID), .o_ack(I_MEM_ACK),
		.o_fault(I_MEM_FAULT), .o_rdata(I_MEM_RDATA));
	initial forever #10 I_CLK = ~I_CLK;
	task conclude;
		$display("checked %0d bad %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task check(input logic [63:0] s, input logic [63:0] e);
		checked++;
		if (s !== e) begin
			bad_count++;
			$display("[ERR] %0t got %h want %h", $time, s, e);
		end
	endtask
	task wr(input [5:0] a, input [31:0] d);
		@(posedge I_CLK);
		I_ADDR <= a;
		I_WDATA <= d;
		I_WR <= 1'b1;
		@(posedge I_CLK);
		I_WR <= 1'b0;
	endtask
	task rd(input [5:0] a, input [31:0] e);
		@(posedge I_CLK);
		I_ADDR <= a;
		I_RD <= 1'b1;
		@(posedge I_CLK);
		I_RD <= 1'b0;
		#1 check(O_RDATA, e);
	endtask
	// Lanes outside the byte enables carry no promise, so they are masked
	task beat(input int i, input [1:0] c, input [63:0] a, input [7:0] b, input [63:0] d);
		logic [63:0] m;
		for (int j = 0; j < 8; j++) m[8*j+:8] = {8{b[j]}};
		check(u_sfcf_mem_model.log_c[i], c);
		check(u_sfcf_mem_model.log_a[i], a);
		check(u_sfcf_mem_model.log_b[i], b);
		if (c == `SFCF_CMD_WRITE) check(u_sfcf_mem_model.log_d[i] & m, d);
	endtask
	task prog(input [31:0] of, input [31:0] dst, input [31:0] xf, input [31:0] dt);
		u_sfcf_mem_model.clear();
		wr(`SFCF_A_OPFLAGS, of);
		wr(`SFCF_A_CREC_LO, 32'h0000_4000);
		wr(`SFCF_A_CREC_HI, '0);
		wr(`SFCF_A_PAT_LO, 32'h4433_2211);
		wr(`SFCF_A_PAT_HI, 32'h8877_6655);
		wr(`SFCF_A_DEST_LO, dst);
		wr(`SFCF_A_DEST_HI, '0);
		wr(`SFCF_A_XFER, xf);
		wr(`SFCF_A_ECOUNT, 32'h0000_0005);
		wr(`SFCF_A_SGLSIZE, 32'h0000_0002);
		wr(`SFCF_A_DTYPE, dt);
	endtask
	task run(input [7:0] code);
		int n;
		wr(`SFCF_A_CTRL, 32'h0000_0001);
		#1 check(O_BUSY, 1'b1);
		n = 0;
		do begin
			@(posedge I_CLK);
			#1 n++;
		end while (O_DONE !== 1'b1 && n < 2000);
		check(n < 2000, 1'b1);
		check(O_BUSY, 1'b0);
		rd(`SFCF_A_STATUS, {16'h0000, code, 8'h02});
	endtask
	task t_fill;
		// List sits clear of every destination, destinations disjoint
		u_sfcf_mem_model.mem[64'h800] = 64'h3;
		u_sfcf_mem_model.mem[64'h808] = 64'h1E;
		prog({`SFCF_OP_SFILL, 24'h0}, 32'h0000_0800, 32'h0000_0014, 32'h00A5_0001);
		run(`SFCF_ST_SUCCESS);
		beat(0, `SFCF_CMD_READ, 64'h800, 8'hFF, '0);
		beat(1, `SFCF_CMD_WRITE, 64'h0, 8'hF8, 64'h5544_3322_1100_0000);
		beat(2, `SFCF_CMD_WRITE, 64'h8, 8'h1F, 64'h0000_0022_1188_7766);
		beat(3, `SFCF_CMD_READ, 64'h808, 8'hFF, '0);
		beat(4, `SFCF_CMD_WRITE, 64'h18, 8'hC0, 64'h2211_0000_0000_0000);
		beat(5, `SFCF_CMD_WRITE, 64'h20, 8'hFF, 64'h2211_8877_6655_4433);
		beat(6, `SFCF_CMD_WRITE, 64'h4000, 8'hFF, 64'h1);
		beat(8, `SFCF_CMD_WRITE, 64'h4010, 8'hFF, '0);
		check(u_sfcf_mem_model.log_h[1], '0);
		rd(`SFCF_A_BDONE, '0);
		rd(`SFCF_A_EDONE, '0);
	endtask
	task t_fault;
		u_sfcf_mem_model.delay = 2;
		u_sfcf_mem_model.fault_at = 64'h20;
		prog({`SFCF_OP_SFILL, 24'h02_0000}, 32'h0000_0800, 32'h0000_0014, 32'hA5C3_0001);
		run(`SFCF_ST_PFAULT);
		check(u_sfcf_mem_model.log_h[4], {1'b1, 16'hA5C3});
		beat(6, `SFCF_CMD_WRITE, 64'h4000, 8'hFF, 64'h0000_000C_0001_0003);
		beat(7, `SFCF_CMD_WRITE, 64'h4008, 8'hFF, 64'h0000_0000_0000_0020);
		beat(8, `SFCF_CMD_WRITE, 64'h4010, 8'hFF, 64'h0000_0001_0000_A5C3);
		rd(`SFCF_A_BDONE, 32'h0000_000C);
		rd(`SFCF_A_EDONE, 32'h0000_0001);
		u_sfcf_mem_model.delay = 0;
		u_sfcf_mem_model.fault_at = '1;
	endtask
	task t_flush;
		prog({`SFCF_OP_FLUSH, 24'h0}, 32'h0000_103F, 32'h0000_0042, '0);
		run(`SFCF_ST_SUCCESS);
		beat(0, `SFCF_CMD_FLUSH, 64'h1000, 8'h00, '0);
		beat(1, `SFCF_CMD_FLUSH, 64'h1040, 8'h00, '0);
		beat(2, `SFCF_CMD_FLUSH, 64'h1080, 8'h00, '0);
		beat(3, `SFCF_CMD_WRITE, 64'h4000, 8'hFF, 64'h1);
		check(u_sfcf_mem_model.log_a.size(), 6);
	endtask
	// Unknown opcode still ends with a record carrying the error status
	task t_badop;
		prog({8'h55, 24'h0}, 32'h0000_0800, 32'h0000_0014, '0);
		run(`SFCF_ST_BADOP);
		beat(0, `SFCF_CMD_WRITE, 64'h4000, 8'hFF, {56'h0, `SFCF_ST_BADOP});
		check(u_sfcf_mem_model.log_a.size(), 3);
	endtask
	initial begin
		#200_000;
		bad_count++;
		conclude();
	end
	initial begin
		repeat (20) @(posedge I_CLK);
		I_RST <= 1'b0;
		rd(`SFCF_A_STATUS, '0);
		rd(`SFCF_A_CAP, 32'h0000_0001);
		rd(6'h02, '0);
		t_fill();
		t_fault();
		t_flush();
		t_badop();
		conclude();
	end
endmodule

// ===== sim/sfcf_mem_model.sv
// Memory-side partner answering the engine's request port
`timescale 1ns/1ps
module sfcf_mem_model (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Requests
	input wire logic i_req,
	input wire logic [1:0] i_cmd,
	input wire logic [63:0] i_addr,
	input wire logic [63:0] i_wdata,
	input wire logic [7:0] i_be,
	input wire logic i_hid_en,
	input wire logic [15:0] i_hid,
	// Answers
	output logic o_ack,
	output logic o_fault,
	output logic [63:0] o_rdata
);
	logic [63:0] mem [logic [63:0]];
	logic [63:0] fault_at = '1;
	int delay = 0;
	int cnt = 0;
	logic [63:0] log_a[$], log_d[$];
	logic [7:0] log_b[$];
	logic [1:0] log_c[$];
	logic [16:0] log_h[$];
	task clear;
		log_a.delete();
		log_d.delete();
		log_b.delete();
		log_c.delete();
		log_h.delete();
	endtask
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_ack <= 1'b0;
			o_fault <= 1'b0;
			o_rdata <= '0;
			cnt <= 0;
		end else begin
			o_ack <= 1'b0;
			o_fault <= 1'b0;
			// Toggle idle data so a stale word never looks valid
			o_rdata <= ~o_rdata;
			if (i_req && !o_ack) begin
				if (cnt < delay) cnt <= cnt + 1;
				else begin
					cnt <= 0;
					o_ack <= 1'b1;
					o_fault <= i_addr == fault_at;
					o_rdata <= mem.exists(i_addr) ? mem[i_addr] : '0;
					log_a.push_back(i_addr);
					log_d.push_back(i_wdata);
					log_b.push_back(i_be);
					log_c.push_back(i_cmd);
					log_h.push_back({i_hid_en, i_hid});
				end
			end
		end
	end
endmodule
